// ==== hw/chg_regs.sv ====
// buck-limit control register and charger status registers
`timescale 1ns/100ps

// Function
// - The control byte's upper nibble sets the buck current limit as 0.5 A plus 100 mA per step.
// - The control byte's lower nibble sets the buck voltage as 4.5 V plus 100 mV per step.
// - A voltage code above hex A is applied as the 5.5 V setting.
// - The control byte resets to hex F6 on reset, on register reset and on watchdog expiry.
// - The optimizer result is a read-only five-bit code of 100 mA steps over 500 mA, untouched by register reset or watchdog.
// - Bits 7 to 5 of the optimizer result byte and bit 3 of the second status byte read zero.
// - The conversion-done bit reads one after a one-shot conversion and always zero in continuous mode.
// - The input current loop bit reads one while that loop regulates.
// - Bit 5 of the first status byte shows the input voltage loop.
// - Bit 4 of the first status byte shows the thermal loop.
// - Bit 3 of the first status byte shows an expired host watchdog.
// - The three-bit charge phase field carries the charger's phase code.
// - The three-bit source field carries the detected input source code.
// - The two-bit optimizer field carries the optimizer state code.
// - The lowest bit of the second status byte shows minimum-system regulation.
module chg_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire chg_regs_pkg::reg_req_type req,
  input wire logic register_reset,
  input wire chg_regs_pkg::charger_live_type live,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [3:0] buck_output_current_limit,
  output logic [3:0] buck_output_voltage_setting,
  output logic [11:0] buck_current_limit_ma,
  output logic [12:0] buck_voltage_mv,
  output logic [11:0] optimized_limit_ma
);

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [4:0] opt_reg;
  logic [7:0] status_first_reg;
  logic [7:0] status_second_reg;
  logic wd_prev_reg;
  logic wd_rise;
  logic sel_ctrl;
  logic sel_opt;
  logic sel_st1;
  logic sel_st2;

  // voltage code as applied; the stored code is kept for readback
  function automatic logic [3:0] clamp_vset(input logic [3:0] code);
    clamp_vset = (code > chg_regs_pkg::VSET_CODE_MAX) ?
      chg_regs_pkg::VSET_CODE_MAX : code;
  endfunction

  function automatic logic [11:0] external_current_limit_pin_ma(input logic [3:0] code);
    external_current_limit_pin_ma = chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_BASE_MA +
      12'(chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_STEP_MA * {8'h00, code});
  endfunction

  function automatic logic [12:0] vset_mv(input logic [3:0] code);
    vset_mv = chg_regs_pkg::VSET_BASE_MV +
      13'(chg_regs_pkg::VSET_STEP_MV * {9'h000, clamp_vset(code)});
  endfunction

  function automatic logic [11:0] opt_ma(input logic [4:0] code);
    opt_ma = chg_regs_pkg::OPT_BASE_MA +
      12'(chg_regs_pkg::OPT_STEP_MA * {7'h00, code});
  endfunction

  function automatic logic hit(input logic [7:0] ofs);
    hit = (req.addr == ofs);
  endfunction

  // assertions read these decodes, since a function body is not sampled
  always_comb begin
    sel_ctrl = hit(chg_regs_pkg::REVERSE_OUTPUT_LIMITS_OFS);
    sel_opt = hit(chg_regs_pkg::OPTIMIZED_INPUT_LIMIT_OFS);
    sel_st1 = hit(chg_regs_pkg::CHARGER_STATUS_FIRST_OFS);
    sel_st2 = hit(chg_regs_pkg::CHARGER_STATUS_SECOND_OFS);
  end

  // only the rising edge restores, so a timer left expired keeps new writes
  assign wd_rise = live.host_timer_expired_status & ~wd_prev_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wd_prev_reg <= 1'b0;
    end else begin
      wd_prev_reg <= live.host_timer_expired_status;
    end
  end

  // reset sources win
  // a write in the same cycle as a reset event is dropped on purpose
  always_comb begin
    ctrl_next = ctrl_reg;
    if (register_reset || wd_rise) begin
      ctrl_next = chg_regs_pkg::REVERSE_OUTPUT_LIMITS_RST;
    end else if (req.wr && hit(chg_regs_pkg::REVERSE_OUTPUT_LIMITS_OFS)) begin
      ctrl_next = req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= chg_regs_pkg::REVERSE_OUTPUT_LIMITS_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buck_output_current_limit <= 4'h0;
      buck_current_limit_ma <= 12'h000;
    end else begin
      buck_output_current_limit <=
        ctrl_reg[chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_MSB:chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_LSB];
      buck_current_limit_ma <=
        external_current_limit_pin_ma(ctrl_reg[chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_MSB:chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_LSB]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buck_output_voltage_setting <= 4'h0;
      buck_voltage_mv <= 13'h0000;
    end else begin
      buck_output_voltage_setting <=
        clamp_vset(ctrl_reg[chg_regs_pkg::VSET_MSB:chg_regs_pkg::VSET_LSB]);
      buck_voltage_mv <=
        vset_mv(ctrl_reg[chg_regs_pkg::VSET_MSB:chg_regs_pkg::VSET_LSB]);
    end
  end

  // optimizer result, only power-on reset clears it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opt_reg <= 5'h00;
      optimized_limit_ma <= 12'h000;
    end else begin
      opt_reg <= live.optimized_input_current_limit;
      optimized_limit_ma <= opt_ma(opt_reg);
    end
  end

  // one-cycle snapshot, so a read shows conditions two edges old
  // conversion done hidden in continuous mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_first_reg <= 8'h00;
    end else begin
      status_first_reg <= {live.adc_done & ~live.adc_continuous,
                           live.input_current_loop_status,
                           live.input_voltage_loop_status,
                           live.thermal_loop_status,
                           live.host_timer_expired_status,
                           live.charge_phase_code};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_second_reg <= 8'h00;
    end else begin
      status_second_reg <= {live.input_power_good_status,
                            live.input_source_type_code,
                            1'b0,
                            live.optimizer_state_code,
                            live.min_system_regulation_status};
    end
  end

  // read path; writes to read-only offsets fall through unused
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (!req.rd) begin
        rd_data <= rd_data;
      end else if (hit(chg_regs_pkg::REVERSE_OUTPUT_LIMITS_OFS)) begin
        rd_data <= ctrl_reg;
      end else if (hit(chg_regs_pkg::OPTIMIZED_INPUT_LIMIT_OFS)) begin
        rd_data <= {3'h0, opt_reg};
      end else if (hit(chg_regs_pkg::CHARGER_STATUS_FIRST_OFS)) begin
        rd_data <= status_first_reg;
      end else if (hit(chg_regs_pkg::CHARGER_STATUS_SECOND_OFS)) begin
        rd_data <= status_second_reg;
      end else begin
        rd_data <= chg_regs_pkg::READ_UNMAPPED;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write;
    req.wr && sel_ctrl && !register_reset && !wd_rise;
  endsequence

  sequence s_ctrl_readback;
    req.rd && sel_ctrl && !req.wr && !register_reset && !wd_rise;
  endsequence

  sequence s_read_opt;
    req.rd && sel_opt && $past(rst_n);
  endsequence

  sequence s_read_st1;
    req.rd && sel_st1 && $past(rst_n);
  endsequence

  sequence s_read_st2;
    req.rd && sel_st2 && $past(rst_n);
  endsequence

  a_external_current_limit_pin_scaling: assert property (
    s_ctrl_write ##1 !register_reset && !wd_rise && !req.wr |=>
      buck_current_limit_ma == external_current_limit_pin_ma($past(req.wdata[7:4], 2)))
    else $error("buck current limit scaling wrong");

  a_vset_scaling: assert property (
    s_ctrl_write ##1 !register_reset && !wd_rise && !req.wr |=>
      buck_voltage_mv == vset_mv($past(req.wdata[3:0], 2)))
    else $error("buck voltage scaling wrong");

  a_vset_clamp: assert property (
    buck_output_voltage_setting <= chg_regs_pkg::VSET_CODE_MAX &&
      buck_voltage_mv <= 13'h157c)
    else $error("buck voltage above ceiling");

  a_external_current_limit_pin_code: assert property (
    1'b1 |=> buck_output_current_limit ==
      $past(ctrl_reg[chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_MSB:chg_regs_pkg::EXTERNAL_CURRENT_LIMIT_PIN_LSB]))
    else $error("applied current code does not follow control byte");

  a_ctrl_write: assert property (
    s_ctrl_write |=> ctrl_reg == $past(req.wdata))
    else $error("control byte write lost");

  a_ctrl_reset: assert property (
    register_reset || wd_rise |=>
      ctrl_reg == chg_regs_pkg::REVERSE_OUTPUT_LIMITS_RST)
    else $error("control byte not restored to default");

  a_ctrl_readback: assert property (
    s_ctrl_readback |=> rd_valid && rd_data == $past(ctrl_reg))
    else $error("control byte readback wrong");

  a_read_strobe: assert property (
    req.rd |=> rd_valid)
    else $error("read answer strobe missing");

  a_read_idle: assert property (
    !req.rd |=> !rd_valid)
    else $error("read answer strobe without a read");

  a_opt_readback: assert property (
    s_read_opt |=>
      rd_data[4:0] == $past(live.optimized_input_current_limit, 2))
    else $error("optimizer result readback wrong");

  a_opt_reserved: assert property (
    s_read_opt |=> (rd_data & chg_regs_pkg::OPT_RESERVED_MASK) == 8'h00)
    else $error("reserved optimizer bits not zero");

  a_st2_reserved: assert property (
    s_read_st2 |=> !rd_data[chg_regs_pkg::ST2_RESERVED])
    else $error("reserved status bit not zero");

  a_adc_continuous: assert property (
    s_read_st1 ##0 $past(live.adc_continuous) |=>
      !rd_data[chg_regs_pkg::ST1_ADC_DONE])
    else $error("conversion done shown in continuous mode");

  a_adc_oneshot: assert property (
    s_read_st1 ##0 !$past(live.adc_continuous) |=>
      rd_data[chg_regs_pkg::ST1_ADC_DONE] == $past(live.adc_done, 2))
    else $error("conversion done bit wrong in one-shot mode");

  a_iin_loop: assert property (
    s_read_st1 |=> rd_data[chg_regs_pkg::ST1_IIN_LOOP] ==
      $past(live.input_current_loop_status, 2))
    else $error("input current loop bit wrong");

  a_vin_loop: assert property (
    s_read_st1 |=> rd_data[chg_regs_pkg::ST1_VIN_LOOP] ==
      $past(live.input_voltage_loop_status, 2))
    else $error("input voltage loop bit wrong");

  a_thermal_loop: assert property (
    s_read_st1 |=> rd_data[chg_regs_pkg::ST1_THERMAL] ==
      $past(live.thermal_loop_status, 2))
    else $error("thermal loop bit wrong");

  a_timer_bit: assert property (
    s_read_st1 |=> rd_data[chg_regs_pkg::ST1_TIMER] ==
      $past(live.host_timer_expired_status, 2))
    else $error("watchdog bit wrong");

  a_phase_field: assert property (
    s_read_st1 |=> rd_data[2:0] == $past(live.charge_phase_code, 2))
    else $error("charge phase field wrong");

  a_power_good: assert property (
    s_read_st2 |=> rd_data[chg_regs_pkg::ST2_POWER_GOOD] ==
      $past(live.input_power_good_status, 2))
    else $error("power good bit wrong");

  a_source_field: assert property (
    s_read_st2 |=> rd_data[6:4] == $past(live.input_source_type_code, 2))
    else $error("source type field wrong");

  a_opt_state: assert property (
    s_read_st2 |=> rd_data[2:1] == $past(live.optimizer_state_code, 2))
    else $error("optimizer state field wrong");

  a_min_sys: assert property (
    s_read_st2 |=> rd_data[chg_regs_pkg::ST2_MIN_SYS] ==
      $past(live.min_system_regulation_status, 2))
    else $error("minimum-system bit wrong");

  a_ro_ignore_write: assert property (
    req.wr && !sel_ctrl &&
      !register_reset && !wd_rise |=> $stable(ctrl_reg))
    else $error("write to read-only offset changed state");

endmodule

// ==== hw/chg_regs_pkg.sv ====
// constants and carrier types for the charger buck-limit and status registers
package chg_regs_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] REVERSE_OUTPUT_LIMITS_OFS = 8'h09;
  localparam logic [7:0] OPTIMIZED_INPUT_LIMIT_OFS = 8'h0a;
  localparam logic [7:0] CHARGER_STATUS_FIRST_OFS = 8'h0b;
  localparam logic [7:0] CHARGER_STATUS_SECOND_OFS = 8'h0c;

  // reverse-output limit register layout and reset value
  localparam logic [7:0] REVERSE_OUTPUT_LIMITS_RST = 8'hf6;
  localparam int EXTERNAL_CURRENT_LIMIT_PIN_MSB = 7;
  localparam int EXTERNAL_CURRENT_LIMIT_PIN_LSB = 4;
  localparam int VSET_MSB = 3;
  localparam int VSET_LSB = 0;
  localparam logic [3:0] VSET_CODE_MAX = 4'ha;

  // analog scaling of the fields
  localparam logic [11:0] EXTERNAL_CURRENT_LIMIT_PIN_BASE_MA = 12'h1f4;
  localparam logic [11:0] EXTERNAL_CURRENT_LIMIT_PIN_STEP_MA = 12'h064;
  localparam logic [12:0] VSET_BASE_MV = 13'h1194;
  localparam logic [12:0] VSET_STEP_MV = 13'h0064;
  localparam logic [11:0] OPT_BASE_MA = 12'h1f4;
  localparam logic [11:0] OPT_STEP_MA = 12'h064;

  // field positions of the status bytes
  localparam int ST1_ADC_DONE = 7;
  localparam int ST1_IIN_LOOP = 6;
  localparam int ST1_VIN_LOOP = 5;
  localparam int ST1_THERMAL = 4;
  localparam int ST1_TIMER = 3;
  localparam int ST2_POWER_GOOD = 7;
  localparam int ST2_RESERVED = 3;
  localparam int ST2_MIN_SYS = 0;
  localparam logic [7:0] OPT_RESERVED_MASK = 8'he0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // charge phase codes
  localparam logic [2:0] PHASE_IDLE = 3'h0;
  localparam logic [2:0] PHASE_TRICKLE = 3'h1;
  localparam logic [2:0] PHASE_PRECHARGE = 3'h2;
  localparam logic [2:0] PHASE_FAST = 3'h3;
  localparam logic [2:0] PHASE_TAPER = 3'h4;
  localparam logic [2:0] PHASE_TOPOFF = 3'h5;
  localparam logic [2:0] PHASE_DONE = 3'h6;
  localparam logic [2:0] PHASE_RESERVED = 3'h7;

  // input source type codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_STD_HOST = 3'h1;
  localparam logic [2:0] SRC_CHG_HOST = 3'h2;
  localparam logic [2:0] SRC_DEDICATED = 3'h3;
  localparam logic [2:0] SRC_WEAK = 3'h4;
  localparam logic [2:0] SRC_UNKNOWN = 3'h5;
  localparam logic [2:0] SRC_NONSTD = 3'h6;
  localparam logic [2:0] SRC_OTG = 3'h7;

  // optimizer state codes
  localparam logic [1:0] OPT_DISABLED = 2'h0;
  localparam logic [1:0] OPT_RUNNING = 2'h1;
  localparam logic [1:0] OPT_DETECTED = 2'h2;
  localparam logic [1:0] OPT_RESERVED = 2'h3;

  // one register access from the serial-port engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // live conditions from the charger core
  typedef struct packed {
    logic adc_done;
    logic adc_continuous;
    logic input_current_loop_status;
    logic input_voltage_loop_status;
    logic thermal_loop_status;
    logic host_timer_expired_status;
    logic [2:0] charge_phase_code;
    logic input_power_good_status;
    logic [2:0] input_source_type_code;
    logic [1:0] optimizer_state_code;
    logic min_system_regulation_status;
    logic [4:0] optimized_input_current_limit;
  } charger_live_type;

endpackage

// ==== test/reg_host.sv ====
// host model driving the byte register port of the register block
`timescale 1ns/100ps
module reg_host (
  input wire logic mclk,
  output chg_regs_pkg::reg_req_type req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  logic timed_out;
  int last_wait;
  initial begin
    req = '0;
    timed_out = 1'b0;
    last_wait = 0;
  end
  // released lines show the inverse, never the stale value
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    int n;
    d = 8'h00;
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    for (n = 0; n < 4; n++) begin
      @(negedge mclk);
      if (rd_valid === 1'b1) break;
    end
    if (n == 4) timed_out = 1'b1;
    last_wait = n;
    d = rd_data;
  endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the buck-limit and status registers
`timescale 1ns/100ps
module tb;
  logic mclk;
  logic rst_n;
  logic register_reset;
  chg_regs_pkg::charger_live_type live;
  chg_regs_pkg::reg_req_type req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [3:0] external_current_limit_pin_code;
  logic [3:0] vset_code;
  logic [11:0] external_current_limit_pin_ma;
  logic [12:0] vset_mv;
  logic [11:0] opt_ma;
  int n_errors;
  int checks_done;
  logic [7:0] got;
  logic [7:0] w;
  logic [7:0] corner [4] = '{8'h0b, 8'hff, 8'h0a, 8'h00};

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  chg_regs dut_u (.mclk(mclk), .rst_n(rst_n), .req(req),
    .register_reset(register_reset), .live(live), .rd_data(rd_data),
    .rd_valid(rd_valid), .buck_output_current_limit(external_current_limit_pin_code),
    .buck_output_voltage_setting(vset_code),
    .buck_current_limit_ma(external_current_limit_pin_ma), .buck_voltage_mv(vset_mv),
    .optimized_limit_ma(opt_ma));
  reg_host host_u (.mclk(mclk), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.read_byte(a, got);
    if (host_u.timed_out) begin
      n_errors++;
      final_report();
    end
    chk("read latency", 16'h0000, 16'(host_u.last_wait));
  endtask
  function automatic logic [3:0] clamp(input logic [3:0] c);
    return (c > 4'ha) ? 4'ha : c;
  endfunction
  function automatic logic [15:0] st1(input chg_regs_pkg::charger_live_type l);
    return {8'h00, l.adc_done & ~l.adc_continuous,
      l.input_current_loop_status, l.input_voltage_loop_status,
      l.thermal_loop_status, l.host_timer_expired_status,
      l.charge_phase_code};
  endfunction
  function automatic logic [15:0] st2(input chg_regs_pkg::charger_live_type l);
    return {8'h00, l.input_power_good_status, l.input_source_type_code,
      1'b0, l.optimizer_state_code, l.min_system_regulation_status};
  endfunction
  task automatic check_ctrl(input logic [7:0] v);
    rd(8'h09);
    chk("ctrl byte", {8'h00, v}, {8'h00, got});
    chk("external_current_limit_pin code", {12'h000, v[7:4]}, {12'h000, external_current_limit_pin_code});
    chk("external_current_limit_pin ma", 16'(500 + 100 * v[7:4]), {4'h0, external_current_limit_pin_ma});
    chk("vset code", {12'h000, clamp(v[3:0])}, {12'h000, vset_code});
    chk("vset mv", 16'(4500 + 100 * clamp(v[3:0])), {3'h0, vset_mv});
  endtask
  task automatic check_live();
    repeat (3) @(posedge mclk);
    rd(8'h0a);
    // reserved top bits must stay clear
    chk("opt byte", {11'h000, live.optimized_input_current_limit},
      {8'h00, got});
    chk("opt ma", 16'(500 + 100 * live.optimized_input_current_limit),
      {4'h0, opt_ma});
    rd(8'h0b);
    chk("status one", st1(live), {8'h00, got});
    rd(8'h0c);
    chk("status two", st2(live), {8'h00, got});
  endtask

  initial begin
    void'($urandom(34));
    rst_n = 1'b0;
    register_reset = 1'b0;
    live = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    check_ctrl(8'hf6);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      w = (i < 4) ? corner[i] : 8'($urandom);
      host_u.write_byte(8'h09, w);
      host_u.write_byte(8'h0a + 8'(i % 3), ~w);
      check_ctrl(w);
    end
    rd(8'h20);
    chk("unmapped", 16'h0000, {8'h00, got});
    $display("test control writes done");
    // corners: all ones, done in continuous mode, then one-shot done
    for (int i = 0; i < 30; i++) begin
      @(posedge mclk);
      if (i == 0) live <= '1;
      else if (i == 1) live <= 21'h180000;
      else if (i == 2) live <= 21'h100000;
      else live <= chg_regs_pkg::charger_live_type'(21'($urandom));
      check_live();
    end
    $display("test live status done");
    @(posedge mclk);
    live <= '0;
    host_u.write_byte(8'h09, 8'h35);
    live.optimized_input_current_limit <= 5'h1f;
    register_reset <= 1'b1;
    @(posedge mclk);
    register_reset <= 1'b0;
    check_ctrl(8'hf6);
    check_live();
    host_u.write_byte(8'h09, 8'h35);
    live.host_timer_expired_status <= 1'b1;
    repeat (3) @(posedge mclk);
    check_ctrl(8'hf6);
    check_live();
    $display("test restore events done");
    final_report();
  end
endmodule
